// ### common/opmd_pkg.sv
package opmd_pkg;

  // frame format codes
  localparam logic [2:0] FMT_DS3_CBIT = 3'h0;
  localparam logic [2:0] FMT_DS3_M23 = 3'h1;
  localparam logic [2:0] FMT_E3_G751 = 3'h2;
  localparam logic [2:0] FMT_E3_G832 = 3'h3;
  localparam logic [2:0] FMT_DS3_UNFR = 3'h4;
  localparam logic [2:0] FMT_E3_UNFR = 3'h6;

  // line interface codes
  localparam logic [2:0] LIF_DUAL_RAIL = 3'h0;
  localparam logic [2:0] LIF_ATT_OFF = 3'h1;
  localparam logic [2:0] LIF_ATT_RX = 3'h2;
  localparam logic [2:0] LIF_ATT_TX = 3'h3;
  localparam int LIF_UNIPOLAR_BIT = 2;

  // register byte offsets
  localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE_STAT = 8'h04;
  localparam logic [7:0] OFS_FEAT_CFG0 = 8'h08;
  localparam logic [7:0] OFS_FEAT_CFG1 = 8'h0C;
  localparam logic [7:0] OFS_FEAT_CFG2 = 8'h10;
  localparam logic [7:0] OFS_FEAT_CFG3 = 8'h14;
  localparam int NUM_FEAT = 4;

  // control register fields
  localparam int POS_FMT = 0;
  localparam int POS_LIF = 4;
  localparam int POS_TX_ZS_DIS = 8;
  localparam int POS_RX_ZS_DIS = 9;
  localparam int POS_TX_PORT_SEL = 10;
  localparam int POS_CLOCK_RATE_ADAPTER_TX = 11;
  localparam int POS_BSCAN = 12;
  localparam logic [12:0] RST_MODE_CTRL = 13'h0000;
  localparam logic [31:0] RST_FEAT_CFG = 32'h0000_0000;

  // status register fields
  localparam int POS_ST_FRAMED = 0;
  localparam int POS_ST_E3 = 1;
  localparam int POS_ST_LINE_UNIT = 2;
  localparam int POS_ST_DUAL = 3;
  localparam int POS_ST_UNIPOLAR = 4;
  localparam int POS_ST_AMI = 5;
  localparam int POS_ST_ATT_RX = 6;
  localparam int POS_ST_ATT_TX = 7;
  localparam int POS_ST_BAD = 8;
  localparam int POS_ST_FEAT_PD = 12;

  // feature index: framer, line interface, jitter att., rate adapter
  localparam int FEAT_FRAMER = 0;
  localparam int FEAT_LINE_UNIT = 1;
  localparam int FEAT_ATT = 2;
  localparam int FEAT_CLOCK_RATE_ADAPTER = 3;

  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    OPMD_IDLE = 3'b001,
    OPMD_ACK = 3'b010,
    OPMD_DONE = 3'b100
  } opmd_bus_e;

endpackage : opmd_pkg

// ### verilog/opmd_decoder.sv
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - format codes 000..011 select DS3 C-bit, M23, E3 G.751, G.832 framed
// - format code 100 is DS3 unframed, 110 is E3 unframed
// - line field 001/010/011: analog, attenuator off/rx/tx, tx port select as written
// - both suppress-disable bits 0 give B3ZS/HDB3, both 1 give AMI
// - line field 000: analog off, dual-rail pins, tx port select as written
// - line field 1XX: unipolar data, suppress bits ignored, tx port select as written
// - unframed analog: format sets adapter rate, line rate and code
// - unframed digital: format sets adapter rate only if adapter clocks tx
// - unused features are powered down with data paths in reset
// - powered-down feature registers stay writable and readable
// - multi-function pins change role with the mode
// - boundary-scan test mode turns every digital pin bidirectional
module opmd_decoder
  import opmd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // mode outputs
  output logic framed_o,
  output logic e3_rate_o,
  output logic ami_o,
  output logic line_unit_on_o,
  output logic att_rx_o,
  output logic att_tx_o,
  output logic clock_rate_adapter_e3_o,
  output logic clock_rate_adapter_en_o,
  output logic mode_bad_o,
  // feature power-down and data-path reset
  output logic [NUM_FEAT-1:0] feat_pd_o,
  output logic [NUM_FEAT-1:0] feat_rst_o,
  // multi-function pin roles
  output logic tx_positive_or_data_o,
  output logic rx_negative_or_code_violation_o,
  output logic tx_clock_or_gapped_out_o,
  output logic tx_frame_start_or_data_valid_o,
  output logic rx_clock_or_gapped_out_o,
  output logic rx_frame_start_or_data_valid_o,
  output logic pins_bidir_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_e3(input logic [2:0] f);
    is_e3 = (f == FMT_E3_G751) || (f == FMT_E3_G832) || (f == FMT_E3_UNFR);
  endfunction : is_e3

  function automatic logic is_valid(input logic [2:0] f);
    is_valid = !f[2] || (f == FMT_DS3_UNFR) || (f == FMT_E3_UNFR);
  endfunction : is_valid

  ////////////////////////////////////////////////////////////////////////////
  logic [12:0] ctrl_q;
  logic [31:0] feat_cfg_q [NUM_FEAT];
  opmd_bus_e bus_q;
  logic [2:0] frame_format_select;
  logic [2:0] line_interface_select;
  logic tx_zero_suppress_disable;
  logic rx_zero_suppress_disable;
  logic tx_line_port_select;
  logic clock_rate_adapter_tx_sel;
  logic bscan;
  logic req;
  logic wr_ack;
  logic [31:0] sel_mask;
  logic [31:0] stat;

  assign frame_format_select = ctrl_q[POS_FMT +: 3];
  assign line_interface_select = ctrl_q[POS_LIF +: 3];
  assign tx_zero_suppress_disable = ctrl_q[POS_TX_ZS_DIS];
  assign rx_zero_suppress_disable = ctrl_q[POS_RX_ZS_DIS];
  assign tx_line_port_select = ctrl_q[POS_TX_PORT_SEL];
  assign clock_rate_adapter_tx_sel = ctrl_q[POS_CLOCK_RATE_ADAPTER_TX];
  assign bscan = ctrl_q[POS_BSCAN];
  assign req = cyc_i && stb_i && (bus_q == OPMD_IDLE);
  // writes land on the ack edge, where the master takes its answer
  assign wr_ack = ack_o && cyc_i && stb_i && we_i;

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_sel
      assign sel_mask[8*b +: 8] = {8{sel_i[b]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mode decode, combinational
  logic d_framed, d_e3, d_unipolar, d_dual, d_line_unit, d_ami, d_bad;
  logic d_att_rx, d_att_tx, d_clock_rate_adapter_en;
  logic [NUM_FEAT-1:0] d_pd;

  always_comb
  begin
    d_framed = !frame_format_select[2];
    d_e3 = is_e3(frame_format_select);
    d_bad = !is_valid(frame_format_select);
    d_unipolar = line_interface_select[LIF_UNIPOLAR_BIT];
    d_dual = (line_interface_select == LIF_DUAL_RAIL);
    d_line_unit = !d_unipolar && !d_dual;
    d_att_rx = (line_interface_select == LIF_ATT_RX);
    d_att_tx = (line_interface_select == LIF_ATT_TX);
    // AMI when both disables set; unipolar ignores them
    d_ami = !d_unipolar && tx_zero_suppress_disable
      && rx_zero_suppress_disable;
    // adapter needed for analog or as tx clock
    d_clock_rate_adapter_en = d_line_unit || clock_rate_adapter_tx_sel;
    d_pd = '0;
    d_pd[FEAT_FRAMER] = !d_framed;
    d_pd[FEAT_LINE_UNIT] = !d_line_unit;
    d_pd[FEAT_ATT] = !(d_att_rx || d_att_tx);
    d_pd[FEAT_CLOCK_RATE_ADAPTER] = !d_clock_rate_adapter_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered mode outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      framed_o <= 1'b1;
      e3_rate_o <= 1'b0;
      ami_o <= 1'b0;
      line_unit_on_o <= 1'b0;
      att_rx_o <= 1'b0;
      att_tx_o <= 1'b0;
      clock_rate_adapter_e3_o <= 1'b0;
      clock_rate_adapter_en_o <= 1'b0;
      mode_bad_o <= 1'b0;
      feat_pd_o <= '1;
      feat_rst_o <= '1;
    end
    else
    begin
      framed_o <= d_framed;
      e3_rate_o <= d_e3;
      ami_o <= d_ami;
      line_unit_on_o <= d_line_unit;
      att_rx_o <= d_att_rx;
      att_tx_o <= d_att_tx;
      clock_rate_adapter_e3_o <= d_e3 && d_clock_rate_adapter_en;
      clock_rate_adapter_en_o <= d_clock_rate_adapter_en;
      mode_bad_o <= d_bad;
      feat_pd_o <= d_pd;
      feat_rst_o <= d_pd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin role select: 1 = second role of each pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_positive_or_data_o <= 1'b0;
      rx_negative_or_code_violation_o <= 1'b0;
      tx_clock_or_gapped_out_o <= 1'b0;
      tx_frame_start_or_data_valid_o <= 1'b0;
      rx_clock_or_gapped_out_o <= 1'b0;
      rx_frame_start_or_data_valid_o <= 1'b0;
      pins_bidir_o <= 1'b0;
    end
    else
    begin
      tx_positive_or_data_o <= d_unipolar;
      rx_negative_or_code_violation_o <= d_unipolar;
      tx_clock_or_gapped_out_o <= !d_framed;
      tx_frame_start_or_data_valid_o <= !d_framed;
      rx_clock_or_gapped_out_o <= !d_framed;
      rx_frame_start_or_data_valid_o <= !d_framed;
      pins_bidir_o <= bscan;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word
  always_comb
  begin
    stat = '0;
    stat[POS_ST_FRAMED] = framed_o;
    stat[POS_ST_E3] = e3_rate_o;
    stat[POS_ST_LINE_UNIT] = line_unit_on_o;
    stat[POS_ST_DUAL] = !line_unit_on_o && !tx_positive_or_data_o;
    stat[POS_ST_UNIPOLAR] = tx_positive_or_data_o;
    stat[POS_ST_AMI] = ami_o;
    stat[POS_ST_ATT_RX] = att_rx_o;
    stat[POS_ST_ATT_TX] = att_tx_o;
    stat[POS_ST_BAD] = mode_bad_o;
    stat[POS_ST_FEAT_PD +: NUM_FEAT] = feat_pd_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone: one wait cycle, ack on second edge, idle cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bus_q <= OPMD_IDLE;
    else
    begin
      case (bus_q)
        OPMD_IDLE: bus_q <= req ? OPMD_ACK : OPMD_IDLE;
        OPMD_ACK: bus_q <= OPMD_DONE;
        OPMD_DONE: bus_q <= OPMD_IDLE;
        default: bus_q <= OPMD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= (bus_q == OPMD_IDLE) && req;
  end

  // control register write; tx port select stored as written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= RST_MODE_CTRL;
    else if (wr_ack && adr_i == OFS_MODE_CTRL)
      ctrl_q <= (ctrl_q & ~sel_mask[12:0]) | (dat_i[12:0] & sel_mask[12:0]);
  end

  // feature configs written regardless of power-down
  generate
    for (genvar f = 0; f < NUM_FEAT; f++)
    begin : g_feat
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          feat_cfg_q[f] <= RST_FEAT_CFG;
        else if (wr_ack && adr_i == OFS_FEAT_CFG0 + 8'(4 * f))
          feat_cfg_q[f] <= (feat_cfg_q[f] & ~sel_mask) | (dat_i & sel_mask);
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= '0;
    else if (req && !we_i)
    begin
      case (adr_i)
        OFS_MODE_CTRL: dat_o <= {19'h0, ctrl_q};
        OFS_MODE_STAT: dat_o <= stat;
        OFS_FEAT_CFG0: dat_o <= feat_cfg_q[0];
        OFS_FEAT_CFG1: dat_o <= feat_cfg_q[1];
        OFS_FEAT_CFG2: dat_o <= feat_cfg_q[2];
        OFS_FEAT_CFG3: dat_o <= feat_cfg_q[3];
        default: dat_o <= UNMAPPED_DATA;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  unframed_rate_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (frame_format_select == FMT_E3_UNFR) |=> !framed_o && e3_rate_o)
    else $error("E3 unframed not decoded");
  framed_code_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (frame_format_select == FMT_DS3_M23) |=> framed_o && !e3_rate_o)
    else $error("DS3 framed not decoded");
  analog_att_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (line_interface_select == LIF_ATT_TX)
    |=> line_unit_on_o && att_tx_o && !att_rx_o)
    else $error("attenuator placement wrong");
  ami_select_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!d_unipolar && tx_zero_suppress_disable && rx_zero_suppress_disable)
    |=> ami_o) else $error("AMI not selected");
  dual_rail_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (line_interface_select == LIF_DUAL_RAIL)
    |=> !line_unit_on_o && feat_pd_o[FEAT_LINE_UNIT])
    else $error("line unit not off");
  unipolar_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    d_unipolar |=> !ami_o && tx_positive_or_data_o)
    else $error("unipolar mode wrong");
  // framer bit left out: reset shows framed with everything powered down
  pd_reset_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    feat_pd_o == feat_rst_o
    && feat_pd_o[FEAT_LINE_UNIT] == !line_unit_on_o
    && feat_pd_o[FEAT_ATT] == !(att_rx_o || att_tx_o)
    && feat_pd_o[FEAT_CLOCK_RATE_ADAPTER] == !clock_rate_adapter_en_o)
    else $error("power-down does not match mode");
  bscan_pins_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(bscan) |=> pins_bidir_o) else $error("pins not bidir");
  clock_rate_adapter_rate_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (d_e3 && d_line_unit) |=> clock_rate_adapter_e3_o && clock_rate_adapter_en_o)
    else $error("adapter rate wrong");
  pin_role_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !d_framed |=> tx_clock_or_gapped_out_o && rx_frame_start_or_data_valid_o)
    else $error("pin role wrong");
  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o ##1 !ack_o) else $error("ack timing wrong");

endmodule : opmd_decoder

// ### bench/opmd_decoder_tb.sv
`timescale 1ns/1ns
module opmd_decoder_tb;
  import opmd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, framed_o, e3_rate_o, ami_o, line_unit_on_o, att_rx_o;
  logic att_tx_o, clock_rate_adapter_e3_o, clock_rate_adapter_en_o, mode_bad_o, pins_bidir_o;
  logic [3:0] feat_pd_o;
  logic [3:0] feat_rst_o;
  logic [5:0] pin_role;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  opmd_decoder dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .framed_o(framed_o),
    .e3_rate_o(e3_rate_o), .ami_o(ami_o),
    .line_unit_on_o(line_unit_on_o), .att_rx_o(att_rx_o),
    .att_tx_o(att_tx_o), .clock_rate_adapter_e3_o(clock_rate_adapter_e3_o),
    .clock_rate_adapter_en_o(clock_rate_adapter_en_o), .mode_bad_o(mode_bad_o),
    .feat_pd_o(feat_pd_o), .feat_rst_o(feat_rst_o),
    .tx_positive_or_data_o(pin_role[0]),
    .rx_negative_or_code_violation_o(pin_role[1]),
    .tx_clock_or_gapped_out_o(pin_role[2]),
    .tx_frame_start_or_data_valid_o(pin_role[3]),
    .rx_clock_or_gapped_out_o(pin_role[4]),
    .rx_frame_start_or_data_valid_o(pin_role[5]),
    .pins_bidir_o(pins_bidir_o)
  );

  always #20 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // hang guard, run needs well under 3000 cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end

  task final_report;
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  ////////////////////////////////////////////////////////////////////////////
  // classic cycle; returns one idle edge after ack so outputs have settled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (n == 50)
      miscompares++;
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // expectations built from control fields only
  task check_mode(input logic [12:0] c);
    logic [2:0] f;
    logic [2:0] l;
    logic fr, e3, upol, lun, ami, ce, bad, jr, jt;
    logic [31:0] r;
    f = c[2:0];
    l = c[6:4];
    fr = ~f[2];
    e3 = (f == 3'h2) || (f == 3'h3) || (f == 3'h6);
    upol = l[2];
    lun = (l != 3'h0) && !upol;
    jr = (l == 3'h2);
    jt = (l == 3'h3);
    ami = !upol && (c[9:8] == 2'h3);
    ce = lun || c[11];
    bad = (f == 3'h5) || (f == 3'h7);
    chk_word(32'({framed_o, e3_rate_o}), 32'({fr, e3}));
    chk_word(32'({line_unit_on_o, att_rx_o, att_tx_o}),
      32'({lun, jr, jt}));
    chk_word(32'({ami_o, mode_bad_o}), 32'({ami, bad}));
    chk_word(32'({clock_rate_adapter_e3_o, clock_rate_adapter_en_o}), 32'({e3 && ce, ce}));
    chk_word(32'(pins_bidir_o), 32'(c[12]));
    chk_word(32'(pin_role), 32'({{4{~fr}}, upol, upol}));
    chk_word(32'({feat_pd_o, feat_rst_o}),
      32'({2{~ce, ~(jr || jt), ~lun, ~fr}}));
    wb(1'b0, OFS_MODE_STAT, 32'h0000_0000, 4'h0, r);
    chk_word(r, 32'({~ce, ~(jr || jt), ~lun, ~fr, 3'h0, bad,
      jt, jr, ami, upol, l == 3'h0, lun, e3, fr}));
    wb(1'b0, OFS_MODE_CTRL, 32'h0000_0000, 4'h0, r);
    chk_word(r, 32'(c));
  endtask : check_mode

  task set_mode(input logic [12:0] c);
    logic [31:0] r;
    wb(1'b1, OFS_MODE_CTRL, 32'(c), 4'hF, r);
    // write lands on the ack edge, outputs register one edge later
    @(posedge clk_i);
    check_mode(c);
  endtask : set_mode

  ////////////////////////////////////////////////////////////////////////////
  task test_mode_sweep;
    logic [12:0] c;
    for (int f = 0; f < 8; f++)
      for (int l = 0; l < 8; l++)
      begin
        c = {f == l, 1'((f ^ l) & 1), (l == 0) || (l > 3), 2'(f + l),
             1'b0, 3'(l), 1'b0, 3'(f)};
        set_mode(c);
      end
  endtask : test_mode_sweep

  // line unit, attenuator and adapter are down in mode 0, storage must still hold
  task test_feat_regs;
    logic [31:0] r;
    logic [7:0] a;
    set_mode(13'h0000);
    for (int i = 0; i < NUM_FEAT; i++)
    begin
      a = OFS_FEAT_CFG0 + 8'(4 * i);
      wb(1'b1, a, 32'h1034_5600 + (i << 24), 4'hF, r);
      wb(1'b1, a, 32'hFFFF_FFFF, 4'h5, r);
      wb(1'b0, a, 32'h0000_0000, 4'h0, r);
      chk_word(r, {8'(16 + i), 24'hFF_56FF});
    end
    wb(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF, r);
    wb(1'b0, 8'h18, 32'h0000_0000, 4'h0, r);
    chk_word(r, UNMAPPED_DATA);
    wb(1'b1, OFS_MODE_STAT, 32'hFFFF_FFFF, 4'hF, r);
    check_mode(13'h0000);
  endtask : test_feat_regs

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // first edge leaves reset, second sees the settled outputs
    repeat (2) @(posedge clk_i);
    check_mode(13'h0000);
    test_mode_sweep();
    test_feat_regs();
    final_report();
  end
endmodule : opmd_decoder_tb
